// ### inc/mhp_pkg.sv
package mhp_pkg;

    // ==========================================================
    // register indices and byte addresses (byte = index * 4)
    localparam logic [5:0] IDX_GROUP_HASH_UPPER = 6'h04;
    localparam logic [5:0] IDX_GROUP_HASH_LOWER = 6'h05;
    localparam logic [5:0] IDX_PHY_MGMT_ACCESS = 6'h06;
    localparam logic [5:0] IDX_PHY_MGMT_WORD = 6'h07;
    localparam logic [5:0] IDX_PAUSE_CONTROL = 6'h08;
    localparam logic [5:0] IDX_MAC_MODE = 6'h10;
    localparam logic [7:0] ADDR_GROUP_HASH_UPPER = {IDX_GROUP_HASH_UPPER, 2'b00};
    localparam logic [7:0] ADDR_GROUP_HASH_LOWER = {IDX_GROUP_HASH_LOWER, 2'b00};
    localparam logic [7:0] ADDR_PHY_MGMT_ACCESS = {IDX_PHY_MGMT_ACCESS, 2'b00};
    localparam logic [7:0] ADDR_PHY_MGMT_WORD = {IDX_PHY_MGMT_WORD, 2'b00};
    localparam logic [7:0] ADDR_PAUSE_CONTROL = {IDX_PAUSE_CONTROL, 2'b00};
    localparam logic [7:0] ADDR_MAC_MODE = {IDX_MAC_MODE, 2'b00};

    // ==========================================================
    // field positions
    localparam int PHY_FIELD_W = 5;
    localparam int MA_PHY_ADDR_LSB = 11;
    localparam int MA_REG_IDX_LSB = 6;
    localparam int MA_WRITE_BIT = 1;
    localparam int MA_BUSY_BIT = 0;
    localparam int WORD_W = 16;
    localparam int PC_TIME_LSB = 16;
    localparam int PC_PASS_BIT = 2;
    localparam int PC_RXEN_BIT = 1;
    localparam int PC_BUSY_BIT = 0;
    localparam int MM_PASS_GROUP_BIT = 0;
    localparam int MM_TX_EN_BIT = 1;
    localparam int MM_FULL_DUPLEX_BIT = 2;

    // ==========================================================
    // reset values and bus answers
    localparam logic [31:0] RST_GROUP_HASH = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ==========================================================
    // hashing and pause frame constants
    localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam logic [47:0] PAUSE_DST_ADDR = 48'h0180_c200_0001;
    localparam logic [15:0] PAUSE_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;

    // ==========================================================
    // states
    typedef enum logic {
        MG_IDLE = 1'b0,
        MG_BUSY = 1'b1
    } mhp_mgmt_state_t;

    typedef enum logic [1:0] {
        FC_IDLE = 2'b00,
        FC_SEND = 2'b01,
        FC_BACKP = 2'b10
    } mhp_fc_state_t;

    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] hash_upper;
        logic [31:0] hash_lower;
        logic [4:0] phy_addr;
        logic [4:0] phy_reg;
        logic phy_write;
        mhp_mgmt_state_t mgmt;
        logic [15:0] phy_word;
        logic [15:0] pause_time;
        logic pass_pause;
        logic pause_rx_en;
        mhp_fc_state_t fc;
        logic fc_req_seen;
        logic [15:0] pause_count;
        logic rx_filter_flag;
        logic rx_filter_valid;
        logic group_accept;
        logic group_done;
        logic pass_every;
        logic tx_enable;
        logic full_duplex;
    } mhp_state_t;

    localparam mhp_state_t MHP_STATE_RST = '0;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// ### inc/mhp_hash_if.sv
`timescale 1ns/10ps
interface mhp_hash_if;
    logic [47:0] dest;
    logic [5:0] index;
    modport hasher (input dest, output index);
    modport user (output dest, input index);
endinterface

// ### logic/mhp_group_hash.sv
`timescale 1ns/10ps
module mhp_group_hash (
    mhp_hash_if.hasher bus
);

    logic [31:0] crc;
    logic fb;

    // ==========================================================
    // crc over the destination, first byte first, lsb first
    always_comb
    begin
        crc = mhp_pkg::CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < 48; i++)
        begin
            fb = crc[31] ^ bus.dest[i];
            crc = {crc[30:0], 1'b0} ^ (fb ? mhp_pkg::CRC_POLY : 32'h0000_0000);
        end
        bus.index = crc[31:26];
    end

endmodule // mhp_group_hash

// ### logic/mhp_regs.sv
`timescale 1ns/10ps
// Behaviour
// - six-bit hash index: top bit picks half register, five bits pick the bit
// - index zero picks lower bit 0, index all ones picks upper bit 31
// - group frame accepted when its hash bit is one, else rejected
// - pass-every-group-frame accepts all group frames regardless of hash table
// - upper hash holds bits 63..32, lower 31..0, read/write, reset zero
// - access bits 10..6 give the PHY register index
// - access bit 1 set means write data word, clear means read into it
// - cycle starts when host sets busy bit; busy holds until access ends
// - read result loaded no later than busy clearing
// - data register holds 16-bit value in bits 15..0, upper bits reserved
// - pause frame built per 802.3x with programmed pause time inserted
// - full duplex: pause busy held until pause frame fully sent
// - half duplex: pause busy held while backpressure is asserted
// - pass-pause-frames never changes which frames are forwarded
// - pause receive enable gates reaction to received pause frames
// - transmitter disabled: no pause frames and no backpressure
// - pause control bits 31..16 hold the pause time value
// - received pause stops transmitter pause time slots; half duplex enables backpressure
// - pass-pause-frames sets the packet filter flag per valid pause frame, else clears
// - pause busy in bit 0 shows sending; host writes it as zero
module mhp_regs (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic rx_group_valid,
    input wire logic [47:0] rx_group_dest,
    output logic rx_group_done,
    output logic rx_group_accept,
    output logic phy_mgmt_req,
    output logic phy_mgmt_write,
    output logic [4:0] phy_mgmt_addr,
    output logic [4:0] phy_mgmt_reg,
    output logic [15:0] phy_mgmt_wdata,
    input wire logic phy_mgmt_done,
    input wire logic [15:0] phy_mgmt_rdata,
    input wire logic fc_request,
    output logic pause_tx_req,
    output logic [47:0] pause_tx_dst,
    output logic [15:0] pause_tx_type,
    output logic [15:0] pause_tx_opcode,
    output logic [15:0] pause_tx_time,
    input wire logic pause_tx_done,
    output logic backpressure,
    input wire logic rx_pause_valid,
    input wire logic [15:0] rx_pause_time,
    input wire logic slot_tick,
    output logic tx_paused,
    output logic rx_filter_valid,
    output logic rx_filter_flag
);

    mhp_pkg::mhp_state_t s_q;
    mhp_pkg::mhp_state_t s_d;
    logic hash_hit;
    logic fc_busy;
    logic do_write;
    logic [32:0] wr_view;
    logic [32:0] rd_view;
    logic [31:0] wr_val;
    mhp_hash_if hash_bus ();

    // ==========================================================
    // hash lookup
    assign hash_bus.dest = rx_group_dest;

    mhp_group_hash u_group_hash (
        .bus(hash_bus)
    );

    assign hash_hit = hash_bus.index[5] ? s_q.hash_upper[hash_bus.index[4:0]]
                                        : s_q.hash_lower[hash_bus.index[4:0]];

    assign fc_busy = (s_q.fc != mhp_pkg::FC_IDLE);

    // ==========================================================
    // register view: {mapped, value}
    function automatic logic [32:0] reg_view(input logic [7:0] addr);
        logic [32:0] v;
        v = 33'h0_0000_0000;
        case (addr)
            mhp_pkg::ADDR_GROUP_HASH_UPPER: v = {1'b1, s_q.hash_upper};
            mhp_pkg::ADDR_GROUP_HASH_LOWER: v = {1'b1, s_q.hash_lower};
            mhp_pkg::ADDR_PHY_MGMT_ACCESS: v = {17'h1_0000, s_q.phy_addr, s_q.phy_reg, 4'h0,
                                                s_q.phy_write, (s_q.mgmt == mhp_pkg::MG_BUSY)};
            mhp_pkg::ADDR_PHY_MGMT_WORD: v = {17'h1_0000, s_q.phy_word};
            mhp_pkg::ADDR_PAUSE_CONTROL: v = {1'b1, s_q.pause_time, 13'h0000, s_q.pass_pause,
                                              s_q.pause_rx_en, fc_busy};
            mhp_pkg::ADDR_MAC_MODE: v = {1'b1, 29'h0000_0000, s_q.full_duplex, s_q.tx_enable, s_q.pass_every};
            default: v = 33'h0_0000_0000;
        endcase
        return v;
    endfunction

    // ==========================================================
    // next state
    always_comb
    begin
        s_d = s_q;
        do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        wr_view = reg_view(s_q.aw_addr);
        rd_view = reg_view(s_axi_araddr);
        wr_val = mhp_pkg::merge_bytes(wr_view[31:0], s_q.w_data, s_q.w_strb);

        // bus capture
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_view[31:0];
            s_d.rresp = rd_view[32] ? mhp_pkg::RESP_OKAY : mhp_pkg::RESP_SLVERR;
        end

        // management cycle end
        unique case (s_q.mgmt)
            mhp_pkg::MG_IDLE:
            begin
                s_d.mgmt = mhp_pkg::MG_IDLE;
            end
            mhp_pkg::MG_BUSY:
            begin
                if (phy_mgmt_done)
                begin
                    s_d.mgmt = mhp_pkg::MG_IDLE;
                    if (!s_q.phy_write)
                    begin
                        s_d.phy_word = phy_mgmt_rdata;
                    end
                end
            end
        endcase

        // group frame filter
        s_d.group_done = rx_group_valid;
        if (rx_group_valid)
        begin
            s_d.group_accept = s_q.pass_every || hash_hit;
        end

        // received pause frames; flag is status only, forwarding is untouched
        s_d.rx_filter_valid = rx_pause_valid;
        if (rx_pause_valid)
        begin
            s_d.rx_filter_flag = s_q.pass_pause;
        end
        if (rx_pause_valid && s_q.pause_rx_en && s_q.full_duplex)
        begin
            s_d.pause_count = rx_pause_time;
        end
        else if (slot_tick && (s_q.pause_count != 16'h0000))
        begin
            s_d.pause_count = s_q.pause_count - 16'h0001;
        end

        // pause transmit and backpressure
        s_d.fc_req_seen = fc_request;
        unique case (s_q.fc)
            mhp_pkg::FC_IDLE:
            begin
                if (s_q.tx_enable && fc_request)
                begin
                    if (s_q.full_duplex)
                    begin
                        if (!s_q.fc_req_seen)
                        begin
                            s_d.fc = mhp_pkg::FC_SEND;
                        end
                    end
                    else if (s_q.pause_rx_en)
                    begin
                        s_d.fc = mhp_pkg::FC_BACKP;
                    end
                end
            end
            mhp_pkg::FC_SEND:
            begin
                if (!s_q.tx_enable || pause_tx_done)
                begin
                    s_d.fc = mhp_pkg::FC_IDLE;
                end
            end
            mhp_pkg::FC_BACKP:
            begin
                if (!s_q.tx_enable || !fc_request || !s_q.pause_rx_en || s_q.full_duplex)
                begin
                    s_d.fc = mhp_pkg::FC_IDLE;
                end
            end
            default:
            begin
                s_d.fc = mhp_pkg::FC_IDLE;
            end
        endcase

        // register writes
        if (do_write)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = mhp_pkg::RESP_OKAY;
            case (s_q.aw_addr)
                mhp_pkg::ADDR_GROUP_HASH_UPPER: s_d.hash_upper = wr_val;
                mhp_pkg::ADDR_GROUP_HASH_LOWER: s_d.hash_lower = wr_val;
                mhp_pkg::ADDR_PHY_MGMT_ACCESS:
                begin
                    if (s_q.mgmt == mhp_pkg::MG_IDLE)
                    begin
                        s_d.phy_addr = wr_val[mhp_pkg::MA_PHY_ADDR_LSB +: mhp_pkg::PHY_FIELD_W];
                        s_d.phy_reg = wr_val[mhp_pkg::MA_REG_IDX_LSB +: mhp_pkg::PHY_FIELD_W];
                        s_d.phy_write = wr_val[mhp_pkg::MA_WRITE_BIT];
                        if (wr_val[mhp_pkg::MA_BUSY_BIT])
                        begin
                            s_d.mgmt = mhp_pkg::MG_BUSY;
                        end
                    end
                end
                mhp_pkg::ADDR_PHY_MGMT_WORD:
                begin
                    if (s_q.mgmt == mhp_pkg::MG_IDLE)
                    begin
                        s_d.phy_word = wr_val[mhp_pkg::WORD_W-1:0];
                    end
                end
                mhp_pkg::ADDR_PAUSE_CONTROL:
                begin
                    if (!fc_busy)
                    begin
                        s_d.pause_time = wr_val[mhp_pkg::PC_TIME_LSB +: mhp_pkg::WORD_W];
                        s_d.pass_pause = wr_val[mhp_pkg::PC_PASS_BIT];
                        s_d.pause_rx_en = wr_val[mhp_pkg::PC_RXEN_BIT];
                    end
                end
                mhp_pkg::ADDR_MAC_MODE:
                begin
                    s_d.pass_every = wr_val[mhp_pkg::MM_PASS_GROUP_BIT];
                    s_d.tx_enable = wr_val[mhp_pkg::MM_TX_EN_BIT];
                    s_d.full_duplex = wr_val[mhp_pkg::MM_FULL_DUPLEX_BIT];
                end
                default: s_d.bresp = mhp_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= mhp_pkg::MHP_STATE_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign rx_group_done = s_q.group_done;
    assign rx_group_accept = s_q.group_accept;
    assign phy_mgmt_req = (s_q.mgmt == mhp_pkg::MG_BUSY);
    assign phy_mgmt_write = s_q.phy_write;
    assign phy_mgmt_addr = s_q.phy_addr;
    assign phy_mgmt_reg = s_q.phy_reg;
    assign phy_mgmt_wdata = s_q.phy_word;
    assign pause_tx_req = (s_q.fc == mhp_pkg::FC_SEND) && s_q.tx_enable;
    assign pause_tx_dst = mhp_pkg::PAUSE_DST_ADDR;
    assign pause_tx_type = mhp_pkg::PAUSE_TYPE;
    assign pause_tx_opcode = mhp_pkg::PAUSE_OPCODE;
    assign pause_tx_time = s_q.pause_time;
    assign backpressure = (s_q.fc == mhp_pkg::FC_BACKP) && s_q.tx_enable;
    assign tx_paused = (s_q.pause_count != 16'h0000);
    assign rx_filter_valid = s_q.rx_filter_valid;
    assign rx_filter_flag = s_q.rx_filter_flag;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence mg_start_s;
        do_write && (s_q.aw_addr == mhp_pkg::ADDR_PHY_MGMT_ACCESS) && s_q.w_strb[0]
            && s_q.w_data[0] && (s_q.mgmt == mhp_pkg::MG_IDLE);
    endsequence

    sequence mg_read_end_s;
        (s_q.mgmt == mhp_pkg::MG_BUSY) && !s_q.phy_write && phy_mgmt_done;
    endsequence

    sequence pause_take_s;
        rx_pause_valid && s_q.pause_rx_en && s_q.full_duplex;
    endsequence

    hash_low_sel_a: assert property (hash_bus.index == 6'h00 |-> hash_hit == s_q.hash_lower[0])
        else $error("index zero does not select lower bit 0");
    hash_high_sel_a: assert property (hash_bus.index == 6'h3f |-> hash_hit == s_q.hash_upper[31])
        else $error("index all ones does not select upper bit 31");
    group_accept_a: assert property (rx_group_valid && !s_q.pass_every
        |=> rx_group_accept == $past(hash_hit))
        else $error("group accept differs from hash bit");
    group_pass_a: assert property (rx_group_valid && s_q.pass_every |=> rx_group_accept && rx_group_done)
        else $error("group frame rejected with pass-every set");
    mgmt_start_a: assert property (mg_start_s |=> phy_mgmt_req && s_axi_bvalid)
        else $error("management cycle did not start");
    mgmt_hold_a: assert property (phy_mgmt_req && !phy_mgmt_done |=> phy_mgmt_req)
        else $error("busy dropped before access completed");
    mgmt_read_a: assert property (mg_read_end_s |=> !phy_mgmt_req && s_q.phy_word == $past(phy_mgmt_rdata))
        else $error("read data not loaded when busy cleared");
    fc_tx_off_a: assert property (!s_q.tx_enable |-> !pause_tx_req && !backpressure)
        else $error("pause activity with transmitter disabled");
    fc_send_busy_a: assert property (pause_tx_req && !pause_tx_done |=> fc_busy)
        else $error("pause busy cleared before frame sent");
    pause_load_a: assert property (pause_take_s |=> s_q.pause_count == $past(rx_pause_time))
        else $error("pause time not loaded");
    pause_flag_a: assert property (rx_pause_valid
        |=> rx_filter_valid && rx_filter_flag == $past(s_q.pass_pause))
        else $error("packet filter flag wrong");

endmodule // mhp_regs

// ### test/mhp_far_model.sv
`timescale 1ns/10ps
module mhp_far_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] dly,
    input wire logic phy_mgmt_req,
    input wire logic phy_mgmt_write,
    input wire logic [4:0] phy_mgmt_reg,
    input wire logic [15:0] phy_mgmt_wdata,
    input wire logic pause_tx_req,
    output logic phy_mgmt_done,
    output logic [15:0] phy_mgmt_rdata,
    output logic pause_tx_done
);
    logic [15:0] mem_q [32];
    logic [15:0] rd_q;
    logic [3:0] cnt_q;
    logic go;
    // outside the done pulse the read bus shows junk, never the old word
    assign phy_mgmt_rdata = phy_mgmt_done ? rd_q : ~rd_q;
    assign go = (phy_mgmt_req | pause_tx_req) && !phy_mgmt_done && !pause_tx_done;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            {cnt_q, rd_q, phy_mgmt_done, pause_tx_done} <= '0;
        else
        begin
            {cnt_q, phy_mgmt_done, pause_tx_done} <= '0;
            if (go)
                cnt_q <= cnt_q + 4'h1;
            if (go && cnt_q == dly)
            begin
                {phy_mgmt_done, pause_tx_done} <= {phy_mgmt_req, !phy_mgmt_req};
                rd_q <= mem_q[phy_mgmt_reg];
                if (phy_mgmt_req && phy_mgmt_write)
                    mem_q[phy_mgmt_reg] <= phy_mgmt_wdata;
            end
        end
    end
endmodule // mhp_far_model

// ### test/tb.sv
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'h0, rst_b = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, rx_group_valid = 1'h0, rx_pause_valid = 1'h0;
    logic fc_request = 1'h0, slot_tick = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rx_group_done, rx_group_accept, phy_mgmt_req, phy_mgmt_write, phy_mgmt_done;
    logic pause_tx_req, pause_tx_done, backpressure, tx_paused, rx_filter_valid, rx_filter_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hf, dly = 4'h0;
    logic [4:0] phy_mgmt_addr, phy_mgmt_reg, ri;
    logic [5:0] x;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [15:0] rx_pause_time = 16'h3, phy_mgmt_wdata, phy_mgmt_rdata, pause_tx_type;
    logic [15:0] pause_tx_opcode, pause_tx_time, pt;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h5163, d, w;
    logic [31:0] h [2];
    logic [47:0] rx_group_dest = 48'h0, pause_tx_dst, g;
    int errors = 0, n_checks = 0;
    always #25 clk_sys = ~clk_sys;
    mhp_regs u_dut (.*);
    mhp_far_model u_far (.*);
    // ==========
    // helpers
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
        n_checks++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bail(input logic t);
        chk("wait limit", 1'h0, t);
        if (t)
            give_verdict();
    endtask
    task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] v);
        int i;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {{3{wr}}, {2{!wr}}};
        for (i = 0; i < 40 && !(wr ? s_axi_bvalid : s_axi_rvalid); i++)
        begin
            @(posedge clk_sys);
            s_axi_awvalid <= s_axi_awvalid & !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid & !s_axi_wready;
            s_axi_arvalid <= s_axi_arvalid & !s_axi_arready;
        end
        bail(!(wr ? s_axi_bvalid : s_axi_rvalid));
        {d, r} = wr ? {d, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
        {s_axi_bready, s_axi_rready} <= 2'h0;
        @(posedge clk_sys);
    endtask
    task automatic poll(input logic [7:0] a);
        for (int i = 0; i < 30 && (i == 0 || d[0]); i++)
            ax(1'h0, a, 32'h0);
        bail(d[0]);
    endtask
    task automatic waitfor(ref logic s, input logic v);
        for (int i = 0; i < 40 && s !== v; i++)
            @(posedge clk_sys);
        bail(s !== v);
    endtask
    task automatic pulse(input logic grp);
        rx_group_valid <= grp;
        rx_pause_valid <= !grp;
        @(posedge clk_sys);
        {rx_group_valid, rx_pause_valid} <= 2'h0;
        @(posedge clk_sys);
    endtask
    function automatic logic [31:0] rnd();
        repeat (16)
            seed = {seed[30:0], 1'h0} ^ (seed[31] ? 32'h0040_0007 : 32'h0);
        return seed;
    endfunction
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c;
        c = mhp_pkg::CRC_INIT;
        for (int k = 0; k < 48; k++)
            c = {c[30:0], 1'h0} ^ ((c[31] ^ a[k]) ? mhp_pkg::CRC_POLY : 32'h0);
        return c[31:26];
    endfunction
    // ==========
    // sequence
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'h1;
        @(posedge clk_sys);
        for (int k = 4; k < 9; k++)
        begin
            ax(1'h0, 8'(k * 4), 32'h0);
            chk("reset value", 128'h0, d);
        end
        for (int k = 0; k < 2; k++)
        begin
            h[k] = rnd();
            ax(1'h1, 8'(16 + 4 * k), h[k]);
            chk("write answer", 2'h0, r);
            ax(1'h0, 8'(16 + 4 * k), 32'h0);
            chk("hash word", h[k], d);
        end
        s_axi_wstrb <= 4'h2;
        ax(1'h1, 8'h10, ~h[0]);
        s_axi_wstrb <= 4'hf;
        h[0][15:8] = ~h[0][15:8];
        ax(1'h0, 8'h10, 32'h0);
        chk("strobe merge", h[0], d);
        ax(1'h0, 8'h2c, 32'h0);
        chk("unmapped read", {32'h0, 2'h2}, {d, r});
        ax(1'h1, 8'h2c, 32'h0);
        chk("unmapped write", 2'h2, r);
        for (int k = 0; k < 28; k++)
        begin
            if (k == 24)
                ax(1'h1, 8'h40, 32'h1);
            g = 48'({rnd(), rnd()});
            x = hidx(g);
            rx_group_dest <= g;
            pulse(1'h1);
            chk("group verdict", {1'h1, k > 23 | h[!x[5]][x[4:0]]},
                {rx_group_done, rx_group_accept});
        end
        w = rnd();
        ri = 5'(rnd());
        ax(1'h1, 8'h1c, w);
        ax(1'h0, 8'h1c, 32'h0);
        chk("mgmt word", {16'h0, w[15:0]}, d);
        ax(1'h1, 8'h18, 32'h0802);
        chk("mgmt idle", 1'h0, phy_mgmt_req);
        dly <= 4'h9;
        ax(1'h1, 8'h18, {16'h0, 5'h01, ri, 6'h3});
        chk("mgmt start", {2'h3, 5'h01, ri, w[15:0]},
            {phy_mgmt_req, phy_mgmt_write, phy_mgmt_addr, phy_mgmt_reg, phy_mgmt_wdata});
        ax(1'h0, 8'h18, 32'h0);
        chk("mgmt busy", 1'h1, d[0]);
        poll(8'h18);
        chk("mgmt end", 1'h0, phy_mgmt_req);
        dly <= 4'h0;
        ax(1'h1, 8'h1c, ~w);
        ax(1'h1, 8'h18, {16'h0, 5'h01, ri, 6'h1});
        poll(8'h18);
        ax(1'h0, 8'h1c, 32'h0);
        chk("mgmt read", {16'h0, w[15:0]}, d);
        pt = 16'(rnd());
        ax(1'h1, 8'h40, 32'h6);
        ax(1'h0, 8'h40, 32'h0);
        chk("mode word", {32'h6, 2'h0}, {d, r});
        ax(1'h1, 8'h20, {pt, 16'h2});
        dly <= 4'h7;
        fc_request <= 1'h1;
        waitfor(pause_tx_req, 1'h1);
        chk("pause frame", {48'h0180_c200_0001, 16'h8808, 16'h0001, pt},
            {pause_tx_dst, pause_tx_type, pause_tx_opcode, pause_tx_time});
        ax(1'h0, 8'h20, 32'h0);
        chk("pause busy", {pt, 16'h3}, d);
        poll(8'h20);
        chk("pause sent", 1'h0, pause_tx_req);
        fc_request <= 1'h0;
        ax(1'h1, 8'h40, 32'h2);
        fc_request <= 1'h1;
        waitfor(backpressure, 1'h1);
        ax(1'h0, 8'h20, 32'h0);
        chk("backpressure busy", 1'h1, d[0]);
        fc_request <= 1'h0;
        waitfor(backpressure, 1'h0);
        ax(1'h0, 8'h20, 32'h0);
        chk("backpressure end", 1'h0, d[0]);
        for (int k = 0; k < 2; k++)
        begin
            ax(1'h1, 8'h40, 32'(4 - 4 * k));
            fc_request <= 1'h1;
            repeat (6) @(posedge clk_sys);
            chk("tx off", 2'h0, {pause_tx_req, backpressure});
            fc_request <= 1'h0;
        end
        ax(1'h1, 8'h40, 32'h6);
        ax(1'h1, 8'h20, 32'h0);
        pulse(1'h0);
        chk("pause ignored", 3'h2, {tx_paused, rx_filter_valid, rx_filter_flag});
        ax(1'h1, 8'h20, 32'h6);
        pulse(1'h0);
        chk("pause taken", 3'h7, {tx_paused, rx_filter_valid, rx_filter_flag});
        slot_tick <= 1'h1;
        repeat (2) @(posedge clk_sys);
        chk("pause hold", 1'h1, tx_paused);
        @(posedge clk_sys);
        slot_tick <= 1'h0;
        @(posedge clk_sys);
        chk("pause over", 1'h0, tx_paused);
        give_verdict();
    end
endmodule // tb
